/* sim/cev_core_model.sv */
// vector fetch side model: acknowledges each exception request
// assumes exc_request from the exception unit, all on hclk
module cev_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic exc_request,
   input wire logic [3:0] svc_dly,
   output logic exc_serviced
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_reg;
   // one pulse per request svc_dly+1 cycles after it rises; never pulses while request is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 4'h0;
         exc_serviced <= 1'b0;
      end else begin
         exc_serviced <= 1'b0;
         if (!exc_request || exc_serviced) begin
            cnt_reg <= 4'h0;
         end else if (cnt_reg >= svc_dly) begin
            exc_serviced <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule : cev_core_model

/* sim/testbench.sv */
// self-checking bench for the exception vector select unit
// assumes cev_core_model as fetch side; registers reached over ahb-lite
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import cev_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] srr;
   cev_instr_t instr = '0;
   cev_complete_t complete = '0;
   cev_msr_t msr = '0;
   logic dec_msb = 1'b0;
   logic exc_serviced;
   logic exc_request;
   logic irq;
   logic [19:0] exc_vector;
   logic [3:0] svc_dly = 4'h0;
   logic [31:0] seed = 32'h5eba;
   logic [31:0] rd;
   logic [31:0] st = 32'h0;
   logic [19:0] vq[$];
   logic [31:0] sq[$];
   int n_mismatch = 0;
   int checks = 0;

   always #25 hclk = ~hclk;
   assign hready = hreadyout;

   cev_exception_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .instr(instr),
      .complete(complete), .msr(msr), .dec_msb(dec_msb), .exc_serviced(exc_serviced),
      .exc_request(exc_request), .exc_vector(exc_vector),
      .save_restore_status_reg(srr), .irq(irq));
   cev_core_model model (.hclk(hclk), .hresetn(hresetn), .exc_request(exc_request),
      .svc_dly(svc_dly), .exc_serviced(exc_serviced));

   task finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // every wait is bounded; running out ends the run as a failure
   task wait_rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 40);
      if (i >= 40) begin
         n_mismatch++;
         finish_test;
      end
   endtask : wait_rdy

   task wreq(input logic lvl);
      int i;
      i = 0;
      while (exc_request !== lvl && i < 40) begin
         @(negedge hclk);
         i++;
      end
      if (i >= 40) begin
         n_mismatch++;
         finish_test;
      end
   endtask : wreq

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      d = hrdata;
   endtask : ahb

   task go(input cev_instr_t v, input cev_complete_t c);
      @(posedge hclk);
      instr <= v;
      complete <= c;
      @(posedge hclk);
      instr <= '0;
      complete <= '0;
   endtask : go

   task setm(input logic [4:0] m);
      @(posedge hclk);
      msr <= m;
   endtask : setm

   task exp(input logic [19:0] v, input logic [31:0] s);
      vq.push_back(v);
      sq.push_back(s);
   endtask : exp

   // model: takes come in queue order, then the request line stays quiet
   task drain;
      logic [19:0] v;
      while (vq.size() > 0) begin
         wreq(1'b1);
         v = vq.pop_front();
         check("vector", {12'h0, exc_vector}, {12'h0, v});
         check("srr", srr, sq.pop_front());
         case (v)
            20'h00700: st[0] = 1'b1;
            20'h00800: st[1] = 1'b1;
            20'h00c00: st[2] = 1'b1;
            20'h00d00: st[3] = 1'b1;
            default: st[4] = 1'b1;
         endcase
         wreq(1'b0);
      end
      repeat (6) @(negedge hclk);
      check("idle", {31'h0, exc_request}, 32'h0);
   endtask : drain

   initial begin
      #1500000;
      n_mismatch++;
      finish_test;
   end

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, CTRL_OFFSET, 32'h0, rd);
      check("ctrl", rd, 32'h1);
      ahb(1'b0, MASK_OFFSET, 32'h0, rd);
      check("mask", rd, 32'h0);
      ahb(1'b1, MASK_OFFSET, 32'h1f, rd);
      setm(5'h10); // problem state, fpu off, external disabled
      go('{valid:1'b1, illegal_op:1'b1, default:'0}, '0);
      exp(20'h00700, 32'h1000);
      drain;
      ahb(1'b0, SRR_OFFSET, 32'h0, rd);
      check("srr_reg", rd, 32'h1000);
      svc_dly <= 4'h5;
      go('{valid:1'b1, privileged_op:1'b1, default:'0}, '0);
      exp(20'h00700, 32'h2000);
      drain;
      go('{valid:1'b1, spr_move_op:1'b1, spr_field_invalid:1'b1, spr_field_bit0:1'b1,
         default:'0}, '0);
      exp(20'h00700, 32'h2000);
      drain;
      go('{valid:1'b1, spr_move_op:1'b1, spr_field_invalid:1'b1, default:'0}, '0);
      exp(20'h00700, 32'h1000);
      drain;
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         go('{valid:1'b1, trap_op:1'b1, trap_select:seed[4:0], trap_compare:seed[9:5],
            default:'0}, '0);
         if ((seed[4:0] & seed[9:5]) != 5'h0) begin
            exp(20'h00700, 32'h4000);
         end
         drain;
      end
      go('{valid:1'b1, fp_op:1'b1, default:'0}, '0);
      exp(20'h00800, 32'h0);
      drain;
      setm(5'h08); // supervisor, fpu on: neither fires
      go('{valid:1'b1, privileged_op:1'b1, fp_op:1'b1, default:'0}, '0);
      drain;
      svc_dly <= 4'h0;
      go('{valid:1'b1, system_call_op:1'b1, default:'0}, '0);
      exp(20'h00c00, 32'h0);
      drain;
      ahb(1'b1, CTRL_OFFSET, 32'h0, rd);
      go('{valid:1'b1, system_call_op:1'b1, default:'0}, '0);
      drain;
      ahb(1'b1, CTRL_OFFSET, 32'h1, rd);
      go('0, '{1'b1, 1'b1});
      drain;
      setm(5'h02);
      go('0, '{1'b1, 1'b0});
      exp(20'h00d00, 32'h0);
      drain;
      setm(5'h01);
      go('0, '{1'b1, 1'b1});
      exp(20'h00d00, 32'h0);
      drain;
      setm(5'h00);
      @(posedge hclk);
      dec_msb <= 1'b1;
      drain;
      ahb(1'b0, PENDING_OFFSET, 32'h0, rd);
      check("pending", rd, 32'h10);
      ahb(1'b1, CTRL_OFFSET, 32'h0, rd);
      setm(5'h04);
      exp(20'h00900, 32'h0);
      drain;
      ahb(1'b1, CTRL_OFFSET, 32'h1, rd);
      @(posedge hclk);
      dec_msb <= 1'b0;
      @(posedge hclk);
      dec_msb <= 1'b1;
      exp(20'h00900, 32'h0);
      drain;
      setm(5'h00);
      go('{valid:1'b1, illegal_op:1'b1, fp_op:1'b1, system_call_op:1'b1, default:'0}, '0);
      exp(20'h00700, 32'h1000);
      exp(20'h00800, 32'h0);
      exp(20'h00c00, 32'h0);
      drain;
      check("irq", {31'h0, irq}, 32'h1);
      ahb(1'b1, VECTOR_OFFSET, 32'hffff_ffff, rd);
      ahb(1'b0, VECTOR_OFFSET, 32'h0, rd);
      check("vec_reg", rd, 32'h00c00);
      ahb(1'b0, 8'h40, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
      check("status", rd, st);
      st = 32'h0;
      repeat (3) @(negedge hclk);
      check("irq_clr", {31'h0, irq}, 32'h0);
      ahb(1'b1, MASK_OFFSET, 32'h0, rd);
      go('{valid:1'b1, system_call_op:1'b1, default:'0}, '0);
      exp(20'h00c00, 32'h0);
      drain;
      check("irq_mask", {31'h0, irq}, 32'h0);
      ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
      check("status2", rd, st);
      check("hresp", {31'h0, hresp}, 32'h0);
      finish_test;
   end
endmodule : testbench

/* src/cev_exception_unit.sv */
// exception detection, vector select and ahb-lite register slave
// assumes pipeline reports are one-cycle strobes synchronous to hclk
// assumes the vector fetch logic pulses exc_serviced once it took the vector
module cev_exception_unit (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire cev_pkg::cev_instr_t instr,
   input wire cev_pkg::cev_complete_t complete,
   input wire cev_pkg::cev_msr_t msr,
   input wire logic dec_msb,
   input wire logic exc_serviced,
   output logic exc_request,
   output logic [19:0] exc_vector,
   output logic [31:0] save_restore_status_reg,
   output logic irq
);
   import cev_pkg::*;

   cev_state_t state_reg;
   cev_state_t state_next;
   logic [31:0] ctrl_reg;
   logic [4:0] status_reg;
   logic [4:0] status_next;
   logic [4:0] mask_reg;
   logic [4:0] pending_reg;
   logic [4:0] pending_next;
   logic [4:0] pending_set;
   logic [4:0] eligible;
   logic [4:0] grant;
   logic [2:0] prog_cause_reg;
   logic [2:0] prog_cause_set;
   logic dec_prev_reg;
   logic enable;
   logic take;
   logic hreadyout_reg;
   logic hresp_reg;
   logic [31:0] hrdata_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic bus_accept;
   logic rd_status;
   logic exc_request_reg;
   logic [19:0] exc_vector_reg;
   logic [31:0] srr_reg;
   logic irq_reg;

   assign enable = ctrl_reg[CTRL_ENABLE_BIT];
   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;
   assign hresp = hresp_reg;
   assign exc_request = exc_request_reg;
   assign exc_vector = exc_vector_reg;
   assign save_restore_status_reg = srr_reg;
   assign irq = irq_reg;

   // condition detection from the execution pipeline
   always_comb begin
      prog_cause_set = 3'h0;
      pending_set = 5'h00;
      if (enable && instr.valid) begin
         if (instr.illegal_op) begin
            prog_cause_set[0] = 1'b1;
         end
         if (instr.spr_move_op && instr.spr_field_invalid) begin
            if (instr.spr_field_bit0 && msr.problem_state_bit) begin
               prog_cause_set[1] = 1'b1;
            end else begin
               // invalid field outside the privileged case is treated as illegal
               prog_cause_set[0] = 1'b1;
            end
         end
         if (instr.privileged_op && msr.problem_state_bit) begin
            prog_cause_set[1] = 1'b1;
         end
         if (instr.trap_op && |(instr.trap_select & instr.trap_compare)) begin
            prog_cause_set[2] = 1'b1;
         end
         pending_set[CLS_PROG] = |prog_cause_set;
         if (instr.fp_op && !msr.fpu_available_bit) begin
            pending_set[CLS_FPU] = 1'b1;
         end
         if (instr.system_call_op) begin
            pending_set[CLS_SC] = 1'b1;
         end
      end
      if (enable && complete.valid) begin
         if (msr.single_step_trace_bit || (complete.is_branch && msr.branch_trace_bit)) begin
            pending_set[CLS_TRACE] = 1'b1;
         end
      end
      if (enable && dec_msb && !dec_prev_reg) begin
         pending_set[CLS_DEC] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_prev_reg <= 1'b0;
      end else begin
         dec_prev_reg <= dec_msb;
      end
   end

   // decrementer waits pending until external enable is set
   always_comb begin
      eligible = pending_reg;
      eligible[CLS_DEC] = pending_reg[CLS_DEC] & msr.external_enable_bit;
   end

   cev_priority_sel #(
      .N(NUM_CLS)
   ) u_sel (
      .req(eligible),
      .grant(grant)
   );

   assign take = (state_reg == CEV_IDLE) && (|eligible);

   // a new condition in the cycle its class is granted stays pending
   always_comb begin
      pending_next = pending_reg;
      if (take) begin
         pending_next = pending_next & ~grant;
      end
      pending_next = pending_next | pending_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_reg <= 5'h00;
      end else begin
         pending_reg <= pending_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prog_cause_reg <= 3'h0;
      end else if (take && grant[CLS_PROG]) begin
         prog_cause_reg <= prog_cause_set;
      end else begin
         prog_cause_reg <= prog_cause_reg | prog_cause_set;
      end
   end

   // request handshake with the vector fetch logic
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CEV_IDLE: begin
            if (take) state_next = CEV_HELD;
         end
         CEV_HELD: begin
            if (exc_serviced) state_next = CEV_GAP;
         end
         CEV_GAP: begin
            state_next = CEV_IDLE;
         end
         default: begin
            state_next = CEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= CEV_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exc_request_reg <= 1'b0;
         exc_vector_reg <= 20'h00000;
      end else if (take) begin
         exc_request_reg <= 1'b1;
         exc_vector_reg <= cev_vector_of(grant);
      end else if (state_reg == CEV_HELD && exc_serviced) begin
         exc_request_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srr_reg <= 32'h0000_0000;
      end else if (take) begin
         srr_reg <= 32'h0000_0000;
         if (grant[CLS_PROG]) begin
            srr_reg[SRR_ILLEGAL_BIT] <= prog_cause_reg[0];
            srr_reg[SRR_PRIV_BIT] <= prog_cause_reg[1];
            srr_reg[SRR_TRAP_BIT] <= prog_cause_reg[2];
         end
      end
   end

   // ahb-lite slave: zero wait states, read data set up at the address phase
   assign bus_accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign rd_status = bus_accept && !hwrite && (haddr[7:0] == STATUS_OFFSET);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         hreadyout_reg <= 1'b1;
         // every access is accepted, so the response stays okay
         hresp_reg <= 1'b0;
         wr_pend_reg <= bus_accept && hwrite;
         if (bus_accept) begin
            wr_addr_reg <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (bus_accept && !hwrite) begin
         if (haddr[7:0] == CTRL_OFFSET) begin
            hrdata_reg <= ctrl_reg;
         end else if (haddr[7:0] == STATUS_OFFSET) begin
            hrdata_reg <= {27'h0, status_reg};
         end else if (haddr[7:0] == MASK_OFFSET) begin
            hrdata_reg <= {27'h0, mask_reg};
         end else if (haddr[7:0] == VECTOR_OFFSET) begin
            hrdata_reg <= {12'h000, exc_vector_reg};
         end else if (haddr[7:0] == SRR_OFFSET) begin
            hrdata_reg <= srr_reg;
         end else if (haddr[7:0] == PENDING_OFFSET) begin
            hrdata_reg <= {27'h0, pending_reg};
         end else begin
            hrdata_reg <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         mask_reg <= MASK_RESET;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == CTRL_OFFSET) begin
            ctrl_reg <= {31'h0, hwdata[CTRL_ENABLE_BIT]};
         end else if (wr_addr_reg == MASK_OFFSET) begin
            mask_reg <= hwdata[4:0];
         end
      end
   end

   // taken exceptions are the events; a take in the read cycle survives the clear
   always_comb begin
      status_next = status_reg;
      if (rd_status) begin
         status_next = 5'h00;
      end
      if (take) begin
         status_next = status_next | grant;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= 5'h00;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   prog_vector_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && grant[CLS_PROG]) |=> exc_request_reg && exc_vector_reg == 20'h00700)
      else $error("program exception not vectored to 00700");

   prog_cause_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && grant[CLS_PROG] && prog_cause_reg[2]) |=> srr_reg[SRR_TRAP_BIT])
      else $error("trap cause missing from save/restore status");

   illegal_capture_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && instr.valid && instr.illegal_op) |=> pending_reg[CLS_PROG] && prog_cause_reg[0])
      else $error("illegal opcode not recorded");

   priv_capture_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && instr.valid && instr.privileged_op && msr.problem_state_bit)
      |=> prog_cause_reg[1])
      else $error("privileged op in problem state not recorded");

   spr_priv_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && instr.valid && instr.spr_move_op && instr.spr_field_invalid
       && instr.spr_field_bit0 && msr.problem_state_bit) |=> prog_cause_reg[1])
      else $error("invalid special register move not privileged");

   trap_capture_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && instr.valid && instr.trap_op && |(instr.trap_select & instr.trap_compare))
      |=> prog_cause_reg[2] && pending_reg[CLS_PROG])
      else $error("true trap condition not recorded");

   fpu_unavail_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && instr.valid && instr.fp_op && !msr.fpu_available_bit)
      |=> pending_reg[CLS_FPU])
      else $error("fp op with fpu unavailable not pending");

   dec_edge_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && $rose(dec_msb)) |=> pending_reg[CLS_DEC])
      else $error("decrementer msb rise not pending");

   dec_gate_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ($rose(exc_request_reg) && exc_vector_reg == 20'h00900)
      |-> $past(msr.external_enable_bit))
      else $error("decrementer taken with external enable clear");

   syscall_vector_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && grant[CLS_SC]) |=> exc_vector_reg == 20'h00c00)
      else $error("system call not vectored to 00c00");

   trace_capture_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (enable && complete.valid && msr.single_step_trace_bit) |=> pending_reg[CLS_TRACE])
      else $error("single step completion not traced");

   one_at_time_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (exc_request_reg && !exc_serviced) |=> exc_request_reg && $stable(exc_vector_reg))
      else $error("exception changed before being serviced");

   service_drop_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (state_reg == CEV_HELD && exc_serviced) |=> !exc_request_reg ##1 !exc_request_reg)
      else $error("request did not drop for two cycles after service");

   irq_level_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && mask_reg[CLS_PROG] && grant[CLS_PROG] && !wr_pend_reg) |=> irq_reg)
      else $error("unmasked taken event did not raise irq");
endmodule : cev_exception_unit

/* src/cev_pkg.sv */
// constants, carrier types and helpers for the core exception vector select unit
// assumes one core clock, inputs synchronous to it, and a single ahb-lite master
package cev_pkg;
   localparam int VEC_W = 20;
   localparam logic [19:0] VEC_PROGRAM = 20'h00700;
   localparam logic [19:0] VEC_FPU_UNAVAIL = 20'h00800;
   localparam logic [19:0] VEC_DECREMENTER = 20'h00900;
   localparam logic [19:0] VEC_SYSTEM_CALL = 20'h00c00;
   localparam logic [19:0] VEC_TRACE = 20'h00d00;
   // class index doubles as priority: lower index wins
   localparam int NUM_CLS = 5;
   localparam int CLS_PROG = 0;
   localparam int CLS_FPU = 1;
   localparam int CLS_SC = 2;
   localparam int CLS_TRACE = 3;
   localparam int CLS_DEC = 4;
   // save/restore status cause bit positions
   localparam int SRR_W = 32;
   localparam int SRR_ILLEGAL_BIT = 12;
   localparam int SRR_PRIV_BIT = 13;
   localparam int SRR_TRAP_BIT = 14;
   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] MASK_OFFSET = 8'h08;
   localparam logic [7:0] VECTOR_OFFSET = 8'h0c;
   localparam logic [7:0] SRR_OFFSET = 8'h10;
   localparam logic [7:0] PENDING_OFFSET = 8'h14;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic problem_state_bit;
      logic fpu_available_bit;
      logic external_enable_bit;
      logic single_step_trace_bit;
      logic branch_trace_bit;
   } cev_msr_t;

   typedef struct packed {
      logic valid;
      logic illegal_op;
      logic privileged_op;
      logic spr_move_op;
      logic spr_field_invalid;
      logic spr_field_bit0;
      logic trap_op;
      logic [4:0] trap_select;
      logic [4:0] trap_compare;
      logic fp_op;
      logic system_call_op;
   } cev_instr_t;

   typedef struct packed {
      logic valid;
      logic is_branch;
   } cev_complete_t;

   typedef enum logic [1:0] {
      CEV_IDLE = 2'b00,
      CEV_HELD = 2'b01,
      CEV_GAP = 2'b11
   } cev_state_t;

   function automatic logic [19:0] cev_vector_of(input logic [4:0] onehot);
      logic [19:0] v;
      v = VEC_PROGRAM;
      if (onehot[CLS_FPU]) v = VEC_FPU_UNAVAIL;
      else if (onehot[CLS_SC]) v = VEC_SYSTEM_CALL;
      else if (onehot[CLS_TRACE]) v = VEC_TRACE;
      else if (onehot[CLS_DEC]) v = VEC_DECREMENTER;
      return v;
   endfunction : cev_vector_of
endpackage : cev_pkg

/* src/cev_priority_sel.sv */
// fixed-priority one-hot grant, lowest index wins
// assumes a purely combinational use inside the exception unit
module cev_priority_sel #(
   parameter int N = 5
) (
   input wire logic [N-1:0] req,
   output logic [N-1:0] grant
);
   always_comb begin
      grant = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            grant = '0;
            grant[i] = 1'b1;
         end
      end
   end
endmodule : cev_priority_sel
